/* File: design/qeo_encoder_out.sv */
// Purpose: Interpolates a signal-period phase into quadrature square-wave tracks
// Assumes: phase_in and phase_valid_in come from on-chip logic on mclk; other inputs are pins
// Notes: Every output leaves a flop; pin paths run three edges deep
// Functional notes
// RQ1: One output edge per equal period division
// RQ2: Interpolation factor fixed per variant, 1..100
// RQ3: Two tracks offset by a quarter period
// RQ4: Step equals spacing of successive edges, both tracks
// RQ5: Counter must catch every edge at least spacing
// RQ6: Counter tolerates spacing minus driver, receiver, cable skew
// RQ7: Reference pulse one increment wide, same position
// RQ8: Counter presets its count on reference pulse
// RQ9: Active-low fault while supply or light fails
// RQ10: Test input routes raw test signals out
// RQ11: Two independent switch outputs from switch tracks
// RQ12: Variant without switches leaves both outputs dead
// RQ13: Reference-select variant: one switch, track picks mark
// RQ14: Counter counts up or down per quadrature phase
`timescale 1ns/10ps
`default_nettype none
`include "qeo_regs.svh"

module qeo_encoder_out #(
   parameter int INTERP = 100,                                 // Edges-steps factor per signal period
   parameter int PHASE_W = 12,                                 // Width of the phase word
   parameter qeo_pkg::qeo_sw_mode_t SW_MODE = qeo_pkg::QEO_SW_TWO  // Switch track variant
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [PHASE_W-1:0] phase_in,
   input wire logic phase_valid_in,
   input wire logic supply_ok_in,
   input wire logic light_ok_in,
   input wire logic test_in,
   input wire logic ref_mark_in,
   input wire logic switch_track_first_in,
   input wire logic switch_track_second_in,
   output logic track_one_out,
   output logic track_one_n_out,
   output logic track_two_out,
   output logic track_two_n_out,
   output logic reference_pulse_out,
   output logic reference_pulse_n_out,
   output logic fault_n_out,
   output logic test_route_out,
   output logic switch_out_first,
   output logic switch_out_second
);
   import qeo_pkg::*;

   // ==========================================================
   // Derived sizes
   localparam int STEPS = 4 * INTERP;                 // Edges per signal period over both tracks
   localparam int SECT_W = $clog2(STEPS);
   localparam int PROD_W = PHASE_W + SECT_W + 1;
   localparam int SEP_NS = (INTERP == 1) ? `QEO_SEP_X1_NS :
                           (INTERP == 5) ? `QEO_SEP_X5_NS :
                           (INTERP == 10) ? `QEO_SEP_X10_NS :
                           (INTERP == 20) ? `QEO_SEP_X20_NS :
                           (INTERP == 25) ? `QEO_SEP_X25_NS :
                           (INTERP == 50) ? `QEO_SEP_X50_NS : `QEO_SEP_X100_NS;
   localparam int SEP_CYC = `QEO_NS_TO_CYC(SEP_NS);  // Least edge spacing in cycles
   localparam int GAP_W = $clog2(SEP_CYC + 1);
   localparam logic [SECT_W-1:0] LAST_SECT = SECT_W'(STEPS - 1);
   localparam logic [SECT_W:0] HALF_STEPS = (SECT_W + 1)'(STEPS / 2);
   localparam logic [SECT_W:0] FULL_STEPS = (SECT_W + 1)'(STEPS);
   localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(SEP_CYC - 1);

   // Only the documented factors are served; refused at elaboration
   if (!(INTERP == 1 || INTERP == 5 || INTERP == 10 || INTERP == 20 ||
         INTERP == 25 || INTERP == 50 || INTERP == 100))
   begin : g_bad_interp
      $error("INTERP must be 1, 5, 10, 20, 25, 50 or 100");  // [RQ2]
   end
   if (PHASE_W < SECT_W)
   begin : g_bad_phase_w
      $error("PHASE_W too narrow for the interpolation factor");
   end

   // ==========================================================
   // Pin synchroniser
   logic [`QEO_PIN_COUNT-1:0] pin_meta_ff;   // First stage, read by second only
   logic [`QEO_PIN_COUNT-1:0] pin_sync_ff;   // Second stage, safe to use
   logic [`QEO_PIN_COUNT-1:0] nxt_pin_meta;
   logic [`QEO_PIN_COUNT-1:0] nxt_pin_sync;

   // Gather the pins into one vector
   always_comb
   begin
      nxt_pin_meta = '0;
      nxt_pin_meta[`QEO_PIN_SUPPLY_OK] = supply_ok_in;
      nxt_pin_meta[`QEO_PIN_LIGHT_OK] = light_ok_in;
      nxt_pin_meta[`QEO_PIN_TEST] = test_in;
      nxt_pin_meta[`QEO_PIN_REF_MARK] = ref_mark_in;
      nxt_pin_meta[`QEO_PIN_SW_FIRST] = switch_track_first_in;
      nxt_pin_meta[`QEO_PIN_SW_SECOND] = switch_track_second_in;
      nxt_pin_sync = pin_meta_ff;
   end

   // Two flops; reset reads as healthy supply and light
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         pin_meta_ff <= `QEO_RST_PINS;
         pin_sync_ff <= `QEO_RST_PINS;
      end
      else
      begin
         pin_meta_ff <= nxt_pin_meta;
         pin_sync_ff <= nxt_pin_sync;
      end
   end

   // ==========================================================
   // Phase to target sector
   logic [PROD_W-1:0] phase_prod;       // Phase scaled by edges per period
   logic [SECT_W-1:0] target_sect;      // Division that the phase lies in

   // Equal divisions of one signal period
   always_comb
   begin
      phase_prod = PROD_W'(phase_in) * PROD_W'(STEPS);              // [RQ1]
      target_sect = SECT_W'(phase_prod >> PHASE_W);                  // [RQ1]
   end

   // ==========================================================
   // Stepper: walks the output one edge at a time toward the target
   logic [SECT_W-1:0] cur_sect_ff;      // Division the outputs stand at
   logic [SECT_W-1:0] tgt_sect_ff;      // Latest sampled target
   logic [1:0] quad_ff;                 // Binary quadrature state, decoded to Gray tracks
   logic [GAP_W-1:0] gap_ff;            // Cycles left before next edge
   logic overrun_ff;                    // Target ran ahead by more than one edge
   logic [SECT_W-1:0] nxt_cur_sect;
   logic [SECT_W-1:0] nxt_tgt_sect;
   logic [1:0] nxt_quad;
   logic [GAP_W-1:0] nxt_gap;
   logic nxt_overrun;
   logic [SECT_W:0] fwd_dist;           // Distance forward, modulo one period
   qeo_dir_t dir;

   // Shortest way round the period decides direction
   always_comb
   begin
      nxt_tgt_sect = phase_valid_in ? target_sect : tgt_sect_ff;
      if (tgt_sect_ff >= cur_sect_ff)
      begin
         fwd_dist = (SECT_W + 1)'(tgt_sect_ff) - (SECT_W + 1)'(cur_sect_ff);
      end
      else
      begin
         fwd_dist = FULL_STEPS + (SECT_W + 1)'(tgt_sect_ff) - (SECT_W + 1)'(cur_sect_ff);
      end
      // Zero distance holds, otherwise pick the nearer side
      if (fwd_dist == '0)
      begin
         dir = QEO_HOLD;
      end
      else if (fwd_dist <= HALF_STEPS)
      begin
         dir = QEO_UP;
      end
      else
      begin
         dir = QEO_DOWN;
      end
      nxt_cur_sect = cur_sect_ff;
      nxt_quad = quad_ff;
      nxt_gap = (gap_ff != '0) ? gap_ff - GAP_W'(1) : gap_ff;
      // More than one edge pending while spacing still runs: edges get late
      nxt_overrun = overrun_ff | ((gap_ff != '0) && (fwd_dist > (SECT_W + 1)'(1)) &&
                                  (fwd_dist < FULL_STEPS - (SECT_W + 1)'(1)));
      // Spacing guard keeps every edge at least SEP_CYC apart
      if (gap_ff == '0)
      begin
         case (dir)
            QEO_UP:
            begin
               nxt_cur_sect = (cur_sect_ff == LAST_SECT) ? '0 : cur_sect_ff + SECT_W'(1);
               nxt_quad = quad_ff + 2'h1;                             // [RQ4]
               nxt_gap = GAP_LOAD;                                    // [RQ5]
            end
            QEO_DOWN:
            begin
               nxt_cur_sect = (cur_sect_ff == '0) ? LAST_SECT : cur_sect_ff - SECT_W'(1);
               nxt_quad = quad_ff - 2'h1;                             // [RQ4]
               nxt_gap = GAP_LOAD;                                    // [RQ5]
            end
            QEO_HOLD:
            begin
               nxt_cur_sect = cur_sect_ff;
            end
            default:
            begin
               nxt_cur_sect = cur_sect_ff;
            end
         endcase
      end
   end

   // Register the stepper
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         cur_sect_ff <= '0;
         tgt_sect_ff <= '0;
         quad_ff <= `QEO_RST_QUAD;
         gap_ff <= '0;
         overrun_ff <= 1'b0;
      end
      else
      begin
         cur_sect_ff <= nxt_cur_sect;
         tgt_sect_ff <= nxt_tgt_sect;
         quad_ff <= nxt_quad;
         gap_ff <= nxt_gap;
         overrun_ff <= nxt_overrun;
      end
   end

   // ==========================================================
   // Output stage, all from flops
   logic t1_ff;
   logic t2_ff;
   logic ref_ff;
   logic fault_n_ff;
   logic test_ff;
   logic sw1_ff;
   logic sw2_ff;
   logic nxt_t1;
   logic nxt_t2;
   logic nxt_ref;
   logic nxt_fault_n;
   logic nxt_test;
   logic nxt_sw1;
   logic nxt_sw2;
   logic ref_gate;                      // Reference mark seen and selected

   // Decode quadrature, reference, fault and switch levels
   always_comb
   begin
      // Sequence 00,01,11,10 puts track two a quarter ahead of track one
      nxt_t1 = nxt_quad[1];                                           // [RQ3]
      nxt_t2 = nxt_quad[1] ^ nxt_quad[0];                             // [RQ3]
      if (SW_MODE == QEO_SW_REF_SEL)
      begin
         // Only the mark under the select tape fires
         ref_gate = pin_sync_ff[`QEO_PIN_REF_MARK] & pin_sync_ff[`QEO_PIN_SW_SECOND];  // [RQ13]
      end
      else
      begin
         ref_gate = pin_sync_ff[`QEO_PIN_REF_MARK];
      end
      // Gating on one quadrature state fixes width and place both ways
      nxt_ref = ref_gate & (nxt_quad == `QEO_RST_QUAD);               // [RQ7]
      nxt_fault_n = pin_sync_ff[`QEO_PIN_SUPPLY_OK] & pin_sync_ff[`QEO_PIN_LIGHT_OK] &
                    ~nxt_overrun;                                     // [RQ9]
      nxt_test = pin_sync_ff[`QEO_PIN_TEST];                          // [RQ10]
      case (SW_MODE)
         QEO_SW_TWO:
         begin
            nxt_sw1 = pin_sync_ff[`QEO_PIN_SW_FIRST];                 // [RQ11]
            nxt_sw2 = pin_sync_ff[`QEO_PIN_SW_SECOND];                // [RQ11]
         end
         QEO_SW_REF_SEL:
         begin
            nxt_sw1 = pin_sync_ff[`QEO_PIN_SW_FIRST];                 // [RQ13]
            nxt_sw2 = 1'b0;                                           // [RQ13]
         end
         default:
         begin
            nxt_sw1 = 1'b0;                                           // [RQ12]
            nxt_sw2 = 1'b0;                                           // [RQ12]
         end
      endcase
   end

   // Register the outputs
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         t1_ff <= 1'b0;
         t2_ff <= 1'b0;
         ref_ff <= 1'b0;
         fault_n_ff <= 1'b1;
         test_ff <= 1'b0;
         sw1_ff <= 1'b0;
         sw2_ff <= 1'b0;
      end
      else
      begin
         t1_ff <= nxt_t1;
         t2_ff <= nxt_t2;
         ref_ff <= nxt_ref;
         fault_n_ff <= nxt_fault_n;
         test_ff <= nxt_test;
         sw1_ff <= nxt_sw1;
         sw2_ff <= nxt_sw2;
      end
   end

   // Differential pairs come from the same flops, so they never skew apart
   assign track_one_out = t1_ff;
   assign track_one_n_out = ~t1_ff;
   assign track_two_out = t2_ff;
   assign track_two_n_out = ~t2_ff;
   assign reference_pulse_out = ref_ff;
   assign reference_pulse_n_out = ~ref_ff;
   assign fault_n_out = fault_n_ff;
   assign test_route_out = test_ff;
   assign switch_out_first = sw1_ff;
   assign switch_out_second = sw2_ff;

endmodule

`default_nettype wire

/* File: shared/qeo_regs.svh */
// Purpose: Constants for the quadrature encoder output block
// Assumes: 40 MHz mclk, times given in nanoseconds
// Notes: Edge separation figures belong to the interpolation variants
`ifndef QEO_REGS_SVH
`define QEO_REGS_SVH

// ==========================================================
// Clock
`define QEO_CLK_PERIOD_NS 25

// ==========================================================
// Least edge separation per interpolation variant
`define QEO_SEP_X1_NS 800
`define QEO_SEP_X5_NS 300
`define QEO_SEP_X10_NS 300
`define QEO_SEP_X20_NS 200
`define QEO_SEP_X25_NS 200
`define QEO_SEP_X50_NS 100
`define QEO_SEP_X100_NS 100

// Least time rounds up to whole cycles
`define QEO_NS_TO_CYC(ns) (((ns) + `QEO_CLK_PERIOD_NS - 1) / `QEO_CLK_PERIOD_NS)

// ==========================================================
// Field layout of the synchronised pin vector
`define QEO_PIN_SUPPLY_OK 0
`define QEO_PIN_LIGHT_OK 1
`define QEO_PIN_TEST 2
`define QEO_PIN_REF_MARK 3
`define QEO_PIN_SW_FIRST 4
`define QEO_PIN_SW_SECOND 5
`define QEO_PIN_COUNT 6

// ==========================================================
// Reset values
`define QEO_RST_QUAD 2'h0
`define QEO_RST_PINS 6'h03

`endif

/* File: shared/qeo_pkg.sv */
// Purpose: Types for the quadrature encoder output block
// Assumes: Nothing beyond the constants header
// Notes: Variant selection travels as an enum parameter
package qeo_pkg;

   // ==========================================================
   // Switch track variants
   typedef enum {
      QEO_SW_NONE,     // No switch functions
      QEO_SW_TWO,      // Two independent switch tracks
      QEO_SW_REF_SEL   // One switch, second track picks the reference mark
   } qeo_sw_mode_t;

   // ==========================================================
   // Step direction toward the interpolated target
   typedef enum {
      QEO_HOLD,
      QEO_UP,
      QEO_DOWN
   } qeo_dir_t;

endpackage

/* File: verif/qeo_checker.sv */
// Purpose: Port assertions for qeo_encoder_out
// Assumes: Every variant spaces edges at least 4 cycles
// Notes: Pin paths are 3 edges deep
`timescale 1ns/10ps
`default_nettype none
module qeo_checker #(
   parameter qeo_pkg::qeo_sw_mode_t SW_MODE = qeo_pkg::QEO_SW_TWO // Switch variant of the bound block
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic supply_ok_in,
   input wire logic light_ok_in,
   input wire logic test_in,
   input wire logic switch_track_first_in,
   input wire logic switch_track_second_in,
   input wire logic track_one_out,
   input wire logic track_one_n_out,
   input wire logic track_two_out,
   input wire logic track_two_n_out,
   input wire logic reference_pulse_out,
   input wire logic reference_pulse_n_out,
   input wire logic fault_n_out,
   input wire logic test_route_out,
   input wire logic switch_out_first,
   input wire logic switch_out_second
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // ==========
   // Track wire form
   property p_pair; track_one_n_out == !track_one_out && track_two_n_out == !track_two_out; endproperty
   a_pair: assert property (p_pair) else $error("track pair not complementary");
   property p_one; !($changed(track_one_out) && $changed(track_two_out)); endproperty
   a_one: assert property (p_one) else $error("both tracks moved at once");
   property p_sep; $changed({track_one_out, track_two_out}) |=> $stable({track_one_out, track_two_out})[*3]; endproperty
   a_sep: assert property (p_sep) else $error("edge spacing too short");
   // ==========
   // Reference pulse, only in quad state 0
   property p_refq; reference_pulse_out |-> !track_one_out && !track_two_out; endproperty
   a_refq: assert property (p_refq) else $error("reference outside state 0");
   property p_refn; reference_pulse_n_out == !reference_pulse_out; endproperty
   a_refn: assert property (p_refn) else $error("reference pair broken");
   // ==========
   // Pin paths, 2 sync flops plus output flop
   property p_fault; !(supply_ok_in && light_ok_in) |-> ##3 !fault_n_out; endproperty
   a_fault: assert property (p_fault) else $error("fault not flagged");
   property p_test; test_route_out == $past(test_in, 3); endproperty
   a_test: assert property (p_test) else $error("test route wrong");
   // Dead switches in the bare variant, second one taken by reference select
   property p_sw1; switch_out_first == ((SW_MODE != qeo_pkg::QEO_SW_NONE) && $past(switch_track_first_in, 3)); endproperty
   a_sw1: assert property (p_sw1) else $error("first switch wrong");
   property p_sw2; switch_out_second == ((SW_MODE == qeo_pkg::QEO_SW_TWO) && $past(switch_track_second_in, 3)); endproperty
   a_sw2: assert property (p_sw2) else $error("second switch wrong");
endmodule
bind qeo_encoder_out qeo_checker #(.SW_MODE(SW_MODE)) u_chk (.mclk, .reset, .supply_ok_in, .light_ok_in, .test_in,
   .switch_track_first_in, .switch_track_second_in, .track_one_out, .track_one_n_out, .track_two_out,
   .track_two_n_out, .reference_pulse_out, .reference_pulse_n_out, .fault_n_out, .test_route_out,
   .switch_out_first, .switch_out_second);
`default_nettype wire

/* File: verif/qeo_counter_model.sv */
// Purpose: Counting control on the far side of the tracks
// Assumes: Sampling on mclk catches every edge
// Notes: Line skew not modelled; spacing margin is ample here
`timescale 1ns/10ps
`default_nettype none
module qeo_counter_model #(
   parameter int PRESET = 1000 // Load value at reference
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic trk_one,
   input wire logic trk_two,
   input wire logic ref_pulse,
   output logic signed [31:0] count
);
   logic [1:0] q_ff; // Last decoded quad state
   logic [1:0] qn; // Present quad state
   assign qn = {trk_one, trk_one ^ trk_two};
   // ==========
   // Edge counter, every mclk edge sampled
   always_ff @(posedge mclk)
   begin
      q_ff <= qn;
      if (reset)
         count <= 0;
      else if (ref_pulse)
         count <= PRESET;
      else if (qn == q_ff + 2'h1)
         count <= count + 1;
      else if (qn == q_ff - 2'h1)
         count <= count - 1;
   end
endmodule
`default_nettype wire

/* File: verif/qeo_encoder_out_tb.sv */
// Purpose: Self-checking bench for qeo_encoder_out
// Assumes: Main instance on defaults, second on reference select with factor 1
// Notes: Walk moves one sector at a time; one deliberate jump trips overrun
`timescale 1ns/10ps
`default_nettype none
module qeo_encoder_out_tb;
   import qeo_pkg::*;
   localparam int PRESET = 1000; // Arbitrary load value
   logic mclk = 0, reset = 1, valid = 0, sup = 1, lit = 1, tst = 0, mark = 0, sw1 = 0, sw2 = 0;
   logic [11:0] phase = 12'h000;
   logic t1, t1n, t2, t2n, rp, rpn, fn, tr, so1, so2;
   logic rp_s, so1_s, so2_s; // Reference-select instance outputs
   logic signed [31:0] cnt; // Far-side count
   logic [3:0] hist [4]; // Expected pin outputs, 3 deep
   int errors = 0, n_compared = 0, pos = 4000, sec = 0, exp_cnt = 0;
   initial forever #12.5 mclk = !mclk;
   qeo_encoder_out DUT (.mclk, .reset, .phase_in(phase), .phase_valid_in(valid), .supply_ok_in(sup),
      .light_ok_in(lit), .test_in(tst), .ref_mark_in(mark), .switch_track_first_in(sw1),
      .switch_track_second_in(sw2), .track_one_out(t1), .track_one_n_out(t1n), .track_two_out(t2),
      .track_two_n_out(t2n), .reference_pulse_out(rp), .reference_pulse_n_out(rpn), .fault_n_out(fn),
      .test_route_out(tr), .switch_out_first(so1), .switch_out_second(so2));
   qeo_counter_model #(.PRESET(PRESET)) u_ctr (.mclk, .reset, .trk_one(t1), .trk_two(t2), .ref_pulse(rp),
      .count(cnt));
   // Second variant: one switch, second track picks the reference mark
   qeo_encoder_out #(.INTERP(1), .SW_MODE(QEO_SW_REF_SEL)) dut_sel (.mclk, .reset, .phase_in(phase),
      .phase_valid_in(valid), .supply_ok_in(sup), .light_ok_in(lit), .test_in(tst), .ref_mark_in(mark),
      .switch_track_first_in(sw1), .switch_track_second_in(sw2), .track_one_out(), .track_one_n_out(),
      .track_two_out(), .track_two_n_out(), .reference_pulse_out(rp_s), .reference_pulse_n_out(),
      .fault_n_out(), .test_route_out(), .switch_out_first(so1_s), .switch_out_second(so2_s));
   // ==========
   // Compare and report
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk_bits(string what, logic [4:0] exp, logic [4:0] got);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_count(logic signed [31:0] exp);
      n_compared++;
      if (cnt !== exp)
      begin
         errors++;
         $display("unexpected count: expected %0d seen %0d", exp, cnt);
      end
   endtask
   // ==========
   // One move of d sectors, then check tracks and count
   task automatic step(int d);
      int q;
      sec = (sec + d + 400) % 400;
      pos += d;
      phase = 12'((sec * 4096 + 399) / 400 + $urandom % 10); // Anywhere inside the sector
      valid = 1;
      @(negedge mclk);
      valid = 0;
      repeat (4 * d * d + 7) @(negedge mclk); // Room for every spaced edge of the move
      q = pos % 4;
      exp_cnt = (mark && q == 0) ? PRESET : exp_cnt + d;
      chk_bits("tracks", {q[1], !q[1], q[1] ^ q[0], !(q[1] ^ q[0]), mark && q == 0}, {t1, t1n, t2, t2n, rp});
      chk_count(exp_cnt);
   endtask
   initial
   begin
      #200000;
      errors++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(76895));
      repeat (12) @(negedge mclk);
      reset = 0;
      // Pins: random levels, outputs follow 3 edges later
      for (int k = 0; k < 80; k++)
      begin
         @(negedge mclk);
         if (k >= 3)
         begin
            chk_bits("pins", {1'b0, hist[(k - 3) % 4]}, {1'b0, fn, tr, so1, so2});
            chk_bits("select pins", {3'h0, hist[(k - 3) % 4][1], 1'b0}, {3'h0, so1_s, so2_s});
         end
         {sup, lit, tst, sw1, sw2} = 5'($urandom);
         hist[k % 4] = {sup & lit, tst, sw1, sw2};
      end
      {sup, lit, tst, sw1, sw2} = 5'h18;
      // Reference select: the mark fires only where the select track agrees
      mark = 1;
      repeat (4) @(negedge mclk);
      exp_cnt = PRESET;
      chk_bits("ref select off", 5'h02, {3'h0, rp, rp_s});
      sw2 = 1;
      repeat (4) @(negedge mclk);
      chk_bits("ref select on", 5'h03, {3'h0, rp, rp_s});
      chk_count(exp_cnt);
      {mark, sw2} = 2'h0;
      repeat (4) @(negedge mclk);
      $display("pin test done");
      // Random walk, wraps the period, reference window midway
      for (int i = 0; i < 300; i++)
      begin
         if (i == 100 || i == 150)
         begin
            mark = (i == 100); // Let the mark settle before moving
            if (mark && pos % 4 == 0)
               exp_cnt = PRESET;
            repeat (4) @(negedge mclk);
         end
         step(i < 10 ? -1 : int'($urandom % 3) - 1);
      end
      chk_bits("no overrun", 5'h08, {1'b0, fn, tr, so1, so2});
      $display("walk test done");
      // Three divisions at once: edges stay spaced, overrun latches a fault
      step(3);
      chk_bits("overrun", 5'h00, {1'b0, fn, tr, so1, so2});
      // Reset in mid-run clears the latched fault and parks the tracks
      reset = 1;
      repeat (3) @(negedge mclk);
      reset = 0;
      sec = 0;
      pos = 4000;
      exp_cnt = 0;
      @(negedge mclk);
      chk_bits("reset tracks", 5'h0a, {t1, t1n, t2, t2n, rp});
      chk_bits("reset fault", 5'h08, {1'b0, fn, tr, so1, so2});
      chk_count(0);
      step(1);
      step(-1);
      $display("jump and reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire
